// ---- rtl/sar_adc_seq_pkg.sv ----
// Constants, register map and carrier types of the converter sequencer.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
package sarseq_pkg;
   localparam int          CLK_MHZ       = 100;
   localparam int          RES_W         = 10;
   localparam int          CONV_TADS     = 11;
   localparam int          ABORT_TADS    = 2;
   localparam int          INSTR_CLKS    = 4;
   localparam int          ADDR_W        = 5;
   // Register byte offsets
   localparam logic [4:0]  OFF_CTRL      = 5'h00;
   localparam logic [4:0]  OFF_ANALOG    = 5'h04;
   localparam logic [4:0]  OFF_RES_HI    = 5'h08;
   localparam logic [4:0]  OFF_RES_LO    = 5'h0C;
   localparam logic [4:0]  OFF_FLAG      = 5'h10;
   localparam logic [4:0]  OFF_IRQEN     = 5'h14;
   // Control register fields
   localparam int          B_ENABLE      = 0;
   localparam int          B_GO          = 1;
   localparam int          B_CHAN        = 2;
   localparam int          B_REF         = 6;
   localparam int          B_FMT         = 7;
   // Analog select, flag and interrupt enable register fields; divider and SAR constants
   localparam int          B_CLKSEL      = 4;
   localparam logic [2:0]  CLKSEL_FRC    = 3'h6;
   localparam logic [3:0]  ANALOG_RST    = 4'hF;
   localparam int          B_DONE        = 0;
   localparam int          B_IRQEN       = 0;
   localparam logic [6:0]  DIV_BASE      = 7'h02;
   localparam logic [9:0]  SAR_MSB       = 10'h200;

   typedef enum logic [1:0] {SQ_IDLE, SQ_DELAY, SQ_CONV, SQ_ABORT} sarseq_state_t;

   typedef struct packed {
      logic                read;
      logic                write;
      logic [ADDR_W-1:0]   address;
      logic [31:0]         writedata;
      logic [3:0]          byteenable;
   } sarseq_avreq_t;

   typedef struct packed {
      logic [31:0]         readdata;
      logic                waitrequest;
   } sarseq_avrsp_t;

   typedef struct packed {
      logic [1:0]          channel;
      logic                refExternal;
      logic                analogOn;
      logic                sampleOpen;
      logic [RES_W-1:0]    trialCode;
   } sarseq_core_t;
endpackage

// ---- rtl/sar_adc_sequencer.sv ----
// Successive-approximation converter sequencer with Avalon-MM register slave.
// Assumes an analog core with trial DAC and comparator, and a free running
// internal conversion oscillator on frcClk.
// Operation
// - Build a 10-bit result by successive approximation into the result pair.
// - Route the selected channel to the sample-and-hold input.
// - Positive reference is supply or external pin; negative always ground.
// - Seven conversion clocks: system clock over 2..64, or internal oscillator.
// - One conversion takes eleven bit periods, exactly eleven with a divided clock.
// - On completion clear go, set done flag, load both result registers.
// - Done flag is set on every completion regardless of interrupt enable.
// - Enabled interrupt on completion raises wake request during sleep.
// - Setting go starts a conversion only if enable was already set.
// - Clearing go mid-conversion aborts it; results keep previous value.
// - After abort wait two bit periods, then resume acquisition.
// - Reset returns all registers to reset, converter off, conversion ended.
// - With internal oscillator, start waits one extra instruction cycle.
// - Sleep, oscillator clock, interrupt off: power down after completion.
// - Sleep with divided clock aborts conversion and powers down.
// - Compare-unit trigger sets go in hardware and resets the timer.
// - Result is left or right justified by the format bit.
// - Left justified: high register holds result bits nine to two.
// - Enable clear disables the converter core.
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module sar_adc_sequencer (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire sarseq_pkg::sarseq_avreq_t avReq,
   output wire sarseq_pkg::sarseq_avrsp_t avRsp,
   input  wire logic                   compHigh,
   input  wire logic                   frcClk,
   input  wire logic                   sleepActive,
   input  wire logic                   specialTrigger,
   output wire sarseq_pkg::sarseq_core_t core,
   output wire logic                   timerReset,
   output wire logic                   wakeIrq
);
   typedef struct packed {
      sarseq_pkg::sarseq_state_t       state;
      logic                            enable;
      logic                            go;
      logic [1:0]                      channel;
      logic                            refExt;
      logic                            fmtRight;
      logic [2:0]                      clkSel;
      logic [3:0]                      anaSel;
      logic [7:0]                      resHi;
      logic [7:0]                      resLo;
      logic                            doneFlag;
      logic                            irqEn;
      logic [9:0]                      sar;
      logic [3:0]                      tadCnt;
      logic [6:0]                      divCnt;
      logic [2:0]                      dlyCnt;
      logic                            powerDown;
      logic                            compS1;
      logic                            compS2;
      logic                            frcS1;
      logic                            frcS2;
      logic                            frcS3;
      sarseq_pkg::sarseq_avrsp_t       rsp;
      sarseq_pkg::sarseq_core_t        pins;
      logic                            timerRst;
      logic                            wake;
   } sarseq_regs_t;

   sarseq_regs_t                       s;
   sarseq_regs_t                       next_s;
   logic                               rstS1;
   logic                               rstS2;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstS1 <= 1'b0;
         rstS2 <= 1'b0;
      end else begin
         rstS1 <= 1'b1;
         rstS2 <= rstS1;
      end
   end

   logic                               frcSel;
   logic                               frcEdge;
   logic [6:0]                         divLast;
   logic                               tadTick;
   logic                               access;
   logic                               wrOk;
   logic [7:0]                         wd;
   logic                               startReq;
   logic                               clrDone;
   logic                               setDone;
   logic [9:0]                         decided;
   logic [3:0]                         bitPos;

   always_comb begin
      next_s = s;
      decided = s.sar;
      bitPos = 4'(sarseq_pkg::CONV_TADS - 1) - s.tadCnt;
      setDone = 1'b0;
      clrDone = 1'b0;
      startReq = 1'b0;
      next_s.timerRst = 1'b0;
      // Synchronisers for the comparator and the oscillator
      next_s.compS1 = compHigh;
      next_s.compS2 = s.compS1;
      next_s.frcS1 = frcClk;
      next_s.frcS2 = s.frcS1;
      next_s.frcS3 = s.frcS2;
      frcSel = (s.clkSel >= sarseq_pkg::CLKSEL_FRC);
      frcEdge = s.frcS2 & ~s.frcS3;
      divLast = 7'((sarseq_pkg::DIV_BASE << s.clkSel) - 7'h01);
      tadTick = frcSel ? frcEdge : (s.divCnt == divLast);
      next_s.divCnt = (tadTick || frcSel) ? 7'h00 : 7'(s.divCnt + 7'h01);
      access = (avReq.read || avReq.write) && !s.rsp.waitrequest;
      wrOk = access && avReq.write && avReq.byteenable[0];
      wd = avReq.writedata[7:0];

      // Conversion sequencing
      unique case (s.state)
         sarseq_pkg::SQ_IDLE: begin
            next_s.tadCnt = 4'h0;
         end
         sarseq_pkg::SQ_DELAY: begin
            next_s.dlyCnt = 3'(s.dlyCnt + 3'h1);
            if (s.dlyCnt == 3'(sarseq_pkg::INSTR_CLKS - 1)) begin
               next_s.state = sarseq_pkg::SQ_CONV;
               next_s.divCnt = 7'h00;
               next_s.tadCnt = 4'h0;
            end
         end
         sarseq_pkg::SQ_CONV: begin
            if (tadTick) begin
               next_s.tadCnt = 4'(s.tadCnt + 4'h1);
               if (s.tadCnt == 4'h0) begin
                  next_s.sar = sarseq_pkg::SAR_MSB;
               end else begin
                  if (!s.compS2) begin
                     decided[bitPos] = 1'b0;
                  end
                  if (bitPos != 4'h0) begin
                     decided[bitPos - 4'h1] = 1'b1;
                  end
                  next_s.sar = decided;
               end
               if (s.tadCnt == 4'(sarseq_pkg::CONV_TADS - 1)) begin
                  next_s.state = sarseq_pkg::SQ_IDLE;
                  next_s.go = 1'b0;
                  setDone = 1'b1;
                  if (s.fmtRight) begin
                     next_s.resHi = {6'h00, decided[9:8]};
                     next_s.resLo = decided[7:0];
                  end else begin
                     next_s.resHi = decided[9:2];
                     next_s.resLo = {decided[1:0], 6'h00};
                  end
                  if (sleepActive && frcSel && !s.irqEn) begin
                     next_s.powerDown = 1'b1;
                  end
               end
            end
         end
         sarseq_pkg::SQ_ABORT: begin
            if (tadTick) begin
               next_s.tadCnt = 4'(s.tadCnt + 4'h1);
               if (s.tadCnt == 4'(sarseq_pkg::ABORT_TADS - 1)) begin
                  next_s.state = sarseq_pkg::SQ_IDLE;
               end
            end
         end
      endcase

      // Register writes
      if (wrOk) begin
         unique case (avReq.address)
            sarseq_pkg::OFF_CTRL: begin
               next_s.enable = wd[sarseq_pkg::B_ENABLE];
               next_s.channel = wd[sarseq_pkg::B_CHAN +: 2];
               next_s.refExt = wd[sarseq_pkg::B_REF];
               next_s.fmtRight = wd[sarseq_pkg::B_FMT];
               if (wd[sarseq_pkg::B_GO] && !s.go) begin
                  startReq = 1'b1;
               end
               if (!wd[sarseq_pkg::B_GO] && s.go) begin
                  next_s.go = 1'b0;
                  next_s.sar = s.sar;
                  next_s.resHi = s.resHi;
                  next_s.resLo = s.resLo;
                  setDone = 1'b0;
                  next_s.state = sarseq_pkg::SQ_ABORT;
                  next_s.tadCnt = 4'h0;
                  next_s.divCnt = 7'h00;
               end
            end
            sarseq_pkg::OFF_ANALOG: begin
               next_s.clkSel = wd[sarseq_pkg::B_CLKSEL +: 3];
               next_s.anaSel = wd[3:0];
            end
            sarseq_pkg::OFF_FLAG: begin
               clrDone = !wd[sarseq_pkg::B_DONE];
            end
            sarseq_pkg::OFF_IRQEN: begin
               next_s.irqEn = wd[sarseq_pkg::B_IRQEN];
            end
            default: begin
            end
         endcase
      end

      // Hardware trigger from the compare unit
      if (specialTrigger) begin
         next_s.timerRst = 1'b1;
         startReq = 1'b1;
      end

      // Start only from an already enabled, idle converter
      if (startReq && s.enable && !s.go && s.state == sarseq_pkg::SQ_IDLE && !s.powerDown) begin
         next_s.go = 1'b1;
         next_s.divCnt = 7'h00;
         next_s.tadCnt = 4'h0;
         next_s.dlyCnt = 3'h0;
         next_s.state = frcSel ? sarseq_pkg::SQ_DELAY : sarseq_pkg::SQ_CONV;
      end

      // Sleep with a divided clock kills the conversion
      if (sleepActive && !frcSel && s.enable) begin
         next_s.powerDown = 1'b1;
         if (s.go) begin
            next_s.go = 1'b0;
            setDone = 1'b0;
            next_s.resHi = s.resHi;
            next_s.resLo = s.resLo;
            next_s.state = sarseq_pkg::SQ_ABORT;
            next_s.tadCnt = 4'h0;
         end
      end
      if (!sleepActive) begin
         next_s.powerDown = 1'b0;
      end

      // Disabling the converter ends everything
      if (!next_s.enable) begin
         next_s.go = 1'b0;
         next_s.state = sarseq_pkg::SQ_IDLE;
         setDone = (s.state == sarseq_pkg::SQ_CONV) && setDone && s.enable;
      end

      // Done flag: set wins over the software clear
      if (setDone) begin
         next_s.doneFlag = 1'b1;
      end else if (clrDone) begin
         next_s.doneFlag = 1'b0;
      end

      // Bus handshake: one wait cycle, then the access edge
      next_s.rsp.waitrequest = !((avReq.read || avReq.write) && s.rsp.waitrequest);
      next_s.rsp.readdata = 32'h0000_0000;
      if ((avReq.read || avReq.write) && s.rsp.waitrequest) begin
         unique case (avReq.address)
            sarseq_pkg::OFF_CTRL: begin
               next_s.rsp.readdata[7:0] = {s.fmtRight, s.refExt, 2'h0, s.channel, s.go, s.enable};
            end
            sarseq_pkg::OFF_ANALOG: begin
               next_s.rsp.readdata[6:0] = {s.clkSel, s.anaSel};
            end
            sarseq_pkg::OFF_RES_HI: begin
               next_s.rsp.readdata[7:0] = s.resHi;
            end
            sarseq_pkg::OFF_RES_LO: begin
               next_s.rsp.readdata[7:0] = s.resLo;
            end
            sarseq_pkg::OFF_FLAG: begin
               next_s.rsp.readdata[sarseq_pkg::B_DONE] = s.doneFlag;
            end
            sarseq_pkg::OFF_IRQEN: begin
               next_s.rsp.readdata[sarseq_pkg::B_IRQEN] = s.irqEn;
            end
            default: begin
            end
         endcase
      end

      // Core pins and side outputs
      next_s.pins.channel = next_s.channel;
      next_s.pins.refExternal = next_s.refExt;
      next_s.pins.analogOn = next_s.enable && !next_s.powerDown;
      next_s.pins.sampleOpen = (next_s.state == sarseq_pkg::SQ_CONV);
      next_s.pins.trialCode = next_s.sar;
      next_s.wake = next_s.doneFlag && next_s.irqEn;
   end

   always_ff @(posedge clk or negedge rstS2) begin
      if (!rstS2) begin
         s <= '0;
         s.state <= sarseq_pkg::SQ_IDLE;
         s.anaSel <= sarseq_pkg::ANALOG_RST;
         s.rsp.waitrequest <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign avRsp = s.rsp;
   assign core = s.pins;
   assign timerReset = s.timerRst;
   assign wakeIrq = s.wake;
endmodule

// ---- sim/sarseq_assertions.sv ----
// Port-level checks of the converter sequencer, bound into its top module.
// Assumes an Avalon-MM master that holds each request until waitrequest is low.
`timescale 1ns/10ps
module sarseq_assertions (
   input wire logic                      clk,
   input wire logic                      reset_n,
   input wire sarseq_pkg::sarseq_avreq_t avReq,
   input wire sarseq_pkg::sarseq_avrsp_t avRsp,
   input wire logic                      sleepActive,
   input wire logic                      specialTrigger,
   input wire sarseq_pkg::sarseq_core_t  core,
   input wire logic                      timerReset,
   input wire logic                      wakeIrq
);
   logic wrAcc;
   logic ctlAcc;
   assign wrAcc = avReq.write && !avRsp.waitrequest;
   assign ctlAcc = wrAcc && avReq.address == sarseq_pkg::OFF_CTRL;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_trig; specialTrigger |=> timerReset; endproperty
   a_trig: assert property (p_trig) else $error("timer reset missing after trigger");
   property p_timer; timerReset |-> $past(specialTrigger); endproperty
   a_timer: assert property (p_timer) else $error("timer reset without trigger");
   property p_chan; $changed(core.channel) |-> $past(ctlAcc) || $past(ctlAcc, 2); endproperty
   a_chan: assert property (p_chan) else $error("channel changed without control write");
   property p_ref; $changed(core.refExternal) |-> $past(ctlAcc) || $past(ctlAcc, 2); endproperty
   a_ref: assert property (p_ref) else $error("reference changed without control write");
   property p_off; $fell(core.analogOn) |-> sleepActive || $past(ctlAcc) || $past(ctlAcc, 2); endproperty
   a_off: assert property (p_off) else $error("converter powered down without cause");
   property p_start; $rose(core.sampleOpen) |-> core.analogOn; endproperty
   a_start: assert property (p_start) else $error("conversion started while disabled");
   property p_len; $rose(core.sampleOpen) |-> core.sampleOpen [*8]; endproperty
   a_len: assert property (p_len) else $error("conversion far too short");
   property p_wake; $rose(wakeIrq) |-> $past(core.sampleOpen) || $past(core.sampleOpen, 2) || $past(wrAcc);
   endproperty
   a_wake: assert property (p_wake) else $error("wake request without completion");
   property p_hold; $fell(wakeIrq) |-> $past(wrAcc) || $past(wrAcc, 2); endproperty
   a_hold: assert property (p_hold) else $error("done flag dropped without software");
endmodule
bind sar_adc_sequencer sarseq_assertions u_chk (.clk(clk), .reset_n(reset_n), .avReq(avReq), .avRsp(avRsp),
   .sleepActive(sleepActive), .specialTrigger(specialTrigger), .core(core), .timerReset(timerReset),
   .wakeIrq(wakeIrq));

// ---- sim/sarseq_core_model.sv ----
// Analog side stand-in: channel mux, reference, comparator and conversion oscillator.
// Assumes the sequencer synchronises compHigh and frcClk to its own clock.
`timescale 1ns/10ps
module sarseq_core_model (
   input  wire logic                     clk,
   input  wire sarseq_pkg::sarseq_core_t core,
   input  wire logic [3:0][9:0]          level,
   output logic                          compHigh,
   output logic                          frcClk
);
   logic       junk = 1'b0;
   logic [9:0] vin;
   initial begin
      frcClk = 1'b0;
      forever #37 frcClk = ~frcClk;
   end
   always @(posedge clk) junk <= ~junk;
   assign vin = core.refExternal ? level[core.channel] >> 1 : level[core.channel];
   assign compHigh = (core.analogOn && core.sampleOpen) ? (vin >= core.trialCode) : junk;
endmodule

// ---- sim/test_sar_adc_sequencer.sv ----
// Self-checking bench for the converter sequencer with an analog core model.
// Assumes the register map and bus timing of the sequencer package.
`timescale 1ns/10ps
module test_sar_adc_sequencer;
   localparam logic [4:0] CTL = sarseq_pkg::OFF_CTRL, ANS = sarseq_pkg::OFF_ANALOG, RHI = sarseq_pkg::OFF_RES_HI;
   localparam logic [4:0] RLO = sarseq_pkg::OFF_RES_LO, FLG = sarseq_pkg::OFF_FLAG, IEN = sarseq_pkg::OFF_IRQEN;
   localparam logic [3:0][9:0] LEVEL = {10'h0C3, 10'h3FF, 10'h15A, 10'h2A5};
   logic                      clk = 1'b0;
   logic                      reset_n = 1'b0;
   sarseq_pkg::sarseq_avreq_t avReq = '0;
   sarseq_pkg::sarseq_avrsp_t avRsp;
   logic                      sleepActive = 1'b0;
   logic                      specialTrigger = 1'b0;
   sarseq_pkg::sarseq_core_t  core;
   logic                      timerReset;
   logic                      wakeIrq;
   logic                      compHigh;
   logic                      frcClk;
   logic [7:0]                rd;
   int                        n_errors = 0;
   int                        num_checks = 0;
   int                        len;
   int                        k;
   initial begin
      forever #5 clk = ~clk;
   end
   sar_adc_sequencer uut (.clk(clk), .reset_n(reset_n), .avReq(avReq), .avRsp(avRsp), .compHigh(compHigh),
      .frcClk(frcClk), .sleepActive(sleepActive), .specialTrigger(specialTrigger), .core(core),
      .timerReset(timerReset), .wakeIrq(wakeIrq));
   sarseq_core_model model (.clk(clk), .core(core), .level(LEVEL), .compHigh(compHigh), .frcClk(frcClk));
   task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
      avReq <= '{read: !w, write: w, address: a, writedata: {24'h000000, d}, byteenable: be};
      do begin
         @(posedge clk);
      end while (avRsp.waitrequest !== 1'b0);
      rd = avRsp.readdata[7:0];
      avReq <= '0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask
   task automatic rchk(input logic [4:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00, 4'hF);
      cmp({2'b00, rd}, {2'b00, e});
   endtask
   task automatic conv;
      while (core.sampleOpen !== 1'b1) @(posedge clk);
      for (len = 0; core.sampleOpen === 1'b1; len++) @(posedge clk);
   endtask
   task automatic t_basic;
      rchk(CTL, 8'h00);
      rchk(ANS, 8'h0F);
      rchk(RHI, 8'h00);
      rchk(FLG, 8'h00);
      rchk(5'h18, 8'h00);
      wr(CTL, 8'h02);
      repeat (40) @(posedge clk);
      rchk(CTL, 8'h00);
      rchk(FLG, 8'h00);
   endtask
   task automatic t_sweep;
      logic [9:0] r;
      logic [7:0] en;
      for (int s = 0; s < 6; s++) begin
         r = s[2] ? LEVEL[s[1:0]] >> 1 : LEVEL[s[1:0]];
         en = {s[0], s[2], 2'b00, s[1:0], 2'b01};
         wr(ANS, {1'b0, s[2:0], 4'hF});
         wr(CTL, en);
         repeat (50) @(posedge clk);
         wr(CTL, en | 8'h02);
         conv;
         cmp({9'h000, len >= 11 * (2 << s) && len <= 11 * (2 << s) + 1}, 10'h001);
         if (s > 0) begin
            rchk(RHI, s[0] ? {6'h00, r[9:8]} : r[9:2]);
            rchk(RLO, s[0] ? r[7:0] : {r[1:0], 6'h00});
         end
         rchk(CTL, en);
         rchk(FLG, 8'h01);
         bus(1'b1, FLG, 8'h00, 4'h0);
         rchk(FLG, 8'h01);
         wr(FLG, 8'h00);
      end
   endtask
   task automatic t_abort;
      wr(CTL, 8'h89);
      repeat (50) @(posedge clk);
      wr(CTL, 8'h8B);
      repeat (100) @(posedge clk);
      wr(CTL, 8'h89);
      rchk(CTL, 8'h89);
      wr(CTL, 8'h8B);
      rchk(CTL, 8'h89);
      repeat (700) @(posedge clk);
      rchk(RLO, LEVEL[1][8:1]);
      rchk(FLG, 8'h00);
      wr(CTL, 8'h8B);
      conv;
      rchk(RHI, 8'h03);
      wr(FLG, 8'h00);
   endtask
   task automatic t_sleep;
      wr(ANS, 8'h6F);
      wr(IEN, 8'h01);
      wr(CTL, 8'h8B);
      cmp({9'h000, core.sampleOpen}, 10'h000);
      sleepActive <= 1'b1;
      for (k = 0; wakeIrq !== 1'b1 && k < 3000; k++) @(posedge clk);
      cmp({9'h000, wakeIrq}, 10'h001);
      cmp({9'h000, core.analogOn}, 10'h001);
      sleepActive <= 1'b0;
      wr(FLG, 8'h00);
      wr(IEN, 8'h00);
      wr(CTL, 8'h8B);
      sleepActive <= 1'b1;
      conv;
      repeat (2) @(posedge clk);
      cmp({9'h000, core.analogOn}, 10'h000);
      rchk(CTL, 8'h89);
      sleepActive <= 1'b0;
      wr(FLG, 8'h00);
      wr(ANS, 8'h2F);
      wr(CTL, 8'h8B);
      repeat (20) @(posedge clk);
      sleepActive <= 1'b1;
      repeat (4) @(posedge clk);
      cmp({9'h000, core.analogOn}, 10'h000);
      sleepActive <= 1'b0;
      rchk(CTL, 8'h89);
      repeat (80) @(posedge clk);
      rchk(FLG, 8'h00);
   endtask
   task automatic t_trig;
      repeat (50) @(posedge clk);
      specialTrigger <= 1'b1;
      @(posedge clk);
      specialTrigger <= 1'b0;
      @(posedge clk);
      cmp({9'h000, timerReset}, 10'h001);
      conv;
      cmp({9'h000, len >= 88 && len <= 89}, 10'h001);
      rchk(FLG, 8'h01);
   endtask
   task automatic t_reset;
      wr(CTL, 8'h8B);
      repeat (20) @(posedge clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      cmp({9'h000, core.sampleOpen}, 10'h000);
      rchk(CTL, 8'h00);
      rchk(ANS, 8'h0F);
      rchk(FLG, 8'h00);
   endtask
   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_basic;
      t_sweep;
      t_abort;
      t_sleep;
      t_trig;
      t_reset;
      conclude;
   end
   initial begin
      #150000;
      n_errors++;
      conclude;
   end
endmodule
